/* File: design/dcc_core_ctrl.sv */
// Core control, capture and safeload target register bank.
// Assumes core taps and program counter share clk; host port on clk too.
//
// Operation
// RL1: Target address registers hold 12 bits; upper bits read zero; reset zero.
// RL2: Two independent readable capture registers snapshot any program point.
// RL3: Each capture has a step index from 0 to 1023.
// RL4: Program counter matching the step copies the chosen core register.
// RL5: Captured value is 5.19, the 5.23 word minus four LSBs.
// RL6: Setup word: step in bits 11:2, source select in bits 1:0.
// RL7: Source 00 mul X, 01 mul Y, 10 MAC result, 11 accumulator feedback.
// RL8: Capture registers are read at locations 2074 and 2075.
// RL9: Core control resets to zero with the documented field layout.
// RL10: Debounce select: 00 20 ms, 01 40 ms, 10 10 ms, 11 5 ms.
// RL11: Aux override bit lets host write aux converter results.
// RL12: Pin override bit lets host write the pin setting register.
// RL13: Interface override bit gives interface registers to the host.
// RL14: Writing 1 to safeload go starts transfer; self-clears on completion.
// RL15: Only pairs written since the last safeload are transferred.
// RL16: Rate select: 512, 256, 128 instructions; 11 reserved.
// RL17: Clear bit low blocks signal flow through the core.
// RL18: ADC and DAC unmute bits reset low and keep paths muted.
// RL19: A safeload finishes within one audio frame of its start.
// RL20: Writing 0 to go does nothing; running transfer completes.
// RL21: Captures refresh every frame at the step, holding between matches.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dcc_core_ctrl import dcc_pkg::*; #(
   parameter int DEB_CYC_00 = DEB_MS_00 * CYC_PER_MS,
   parameter int DEB_CYC_01 = DEB_MS_01 * CYC_PER_MS,
   parameter int DEB_CYC_10 = DEB_MS_10 * CYC_PER_MS,
   parameter int DEB_CYC_11 = DEB_MS_11 * CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [DATA_W-1:0] rdata,
   // Core taps
   input wire logic step_valid,
   input wire logic [STEP_W-1:0] prog_counter,
   input wire dcc_tap_s taps,
   // Core and converter controls
   output logic core_clear_n,
   output logic adc_unmute,
   output logic dac_unmute,
   output logic [1:0] rate_multiplier_sel,
   output logic [10:0] instr_per_sample,
   output logic [1:0] input_debounce_sel,
   output logic [DEB_W-1:0] debounce_ticks,
   output logic aux_conv_host_write,
   output logic pin_host_write,
   output logic iface_host_write,
   // Parameter memory load
   output logic safeload_go,
   output logic ld_valid,
   output logic [2:0] ld_slot,
   output logic [TGT_W-1:0] param_target_addr
);
   initial begin
      if (DEB_CYC_00 < 1 || DEB_CYC_00 >= (1 << DEB_W) ||
          DEB_CYC_01 < 1 || DEB_CYC_01 >= (1 << DEB_W) ||
          DEB_CYC_10 < 1 || DEB_CYC_10 >= (1 << DEB_W) ||
          DEB_CYC_11 < 1 || DEB_CYC_11 >= (1 << DEB_W)) begin
         $error("debounce counts must fit the tick field");
      end
   end

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Decoders
   // ------------------------------------------------------------
   function automatic logic [10:0] ips_of(input logic [1:0] sel);
      case (sel)
         2'h1: ips_of = IPS_2X;
         2'h2: ips_of = IPS_4X;
         // Reserved code falls back to the single-rate program length
         default: ips_of = IPS_1X;
      endcase
   endfunction

   function automatic logic [DEB_W-1:0] deb_of(input logic [1:0] sel);
      case (sel)
         2'h1: deb_of = DEB_W'(DEB_CYC_01);
         2'h2: deb_of = DEB_W'(DEB_CYC_10);
         2'h3: deb_of = DEB_W'(DEB_CYC_11);
         default: deb_of = DEB_W'(DEB_CYC_00);
      endcase
   endfunction

   function automatic logic [WORD_W-1:0] tap_of(input dcc_tap_s t,
                                                input logic [1:0] sel);
      case (sel)
         SRC_MUL_X: tap_of = t.mul_x;
         SRC_MUL_Y: tap_of = t.mul_y;
         SRC_MAC: tap_of = t.mac_result;
         default: tap_of = t.acc_fb;
      endcase
   endfunction

   logic wr_ctrl;
   logic wr_tgt;
   logic [2:0] tgt_slot;

   assign wr_ctrl = wr_stb && addr == OFS_CORE_CTRL;
   assign wr_tgt = wr_stb && addr >= OFS_LOAD_TGT0 &&
                   addr < OFS_LOAD_TGT0 + 12'(LOAD_SLOTS);
   assign tgt_slot = 3'(addr - OFS_LOAD_TGT0);

   // ------------------------------------------------------------
   // Core control register
   // ------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic go_start;
   logic load_busy;

   // The go bit is not stored here; it mirrors the sequencer
   assign ctrl_next = wdata & CTRL_MASK & ~(16'h0001 << B_GO);
   assign go_start = wr_ctrl && wdata[B_GO] && !load_busy; // [RL14] [RL20]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= RST_CTRL; // [RL9] [RL18]
      end else if (wr_ctrl) begin
         ctrl_reg <= ctrl_next; // [RL9]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_clear_n <= 1'b0;
         adc_unmute <= 1'b0;
         dac_unmute <= 1'b0;
         rate_multiplier_sel <= 2'h0;
         input_debounce_sel <= 2'h0;
         aux_conv_host_write <= 1'b0;
         pin_host_write <= 1'b0;
         iface_host_write <= 1'b0;
      end else begin
         core_clear_n <= ctrl_reg[B_CLR_N]; // [RL17]
         adc_unmute <= ctrl_reg[B_ADC_UM]; // [RL18]
         dac_unmute <= ctrl_reg[B_DAC_UM]; // [RL18]
         rate_multiplier_sel <= ctrl_reg[B_RATE_LO +: 2];
         input_debounce_sel <= ctrl_reg[B_DEB_LO +: 2];
         aux_conv_host_write <= ctrl_reg[B_AUX_HW]; // [RL11]
         pin_host_write <= ctrl_reg[B_PIN_HW]; // [RL12]
         iface_host_write <= ctrl_reg[B_IF_HW]; // [RL13]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_per_sample <= IPS_1X;
         debounce_ticks <= DEB_W'(DEB_CYC_00);
      end else begin
         instr_per_sample <= ips_of(ctrl_reg[B_RATE_LO +: 2]); // [RL16]
         debounce_ticks <= deb_of(ctrl_reg[B_DEB_LO +: 2]); // [RL10]
      end
   end

   // ------------------------------------------------------------
   // Safeload sequencer
   // ------------------------------------------------------------
   logic [LOAD_SLOTS*TGT_W-1:0] tgt_flat;

   dcc_safeload u_load (
      .clk(clk),
      .rst_n(rst_n),
      .tgt_we(wr_tgt),
      .tgt_slot(tgt_slot),
      .tgt_addr(wdata[TGT_W-1:0]), // [RL1]
      .start(go_start),
      .busy(load_busy),
      .tgt_flat(tgt_flat),
      .ld_valid(ld_valid),
      .ld_slot(ld_slot),
      .ld_addr(param_target_addr)
   );

   assign safeload_go = load_busy;

   // ------------------------------------------------------------
   // Capture slots
   // ------------------------------------------------------------
   dcc_setup_s setup_reg [2];
   logic [DATA_W-1:0] capt_reg [2];

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_capt
         logic [WORD_W-1:0] tap_word;

         assign tap_word = tap_of(taps, setup_reg[c].capture_source_sel);

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               setup_reg[c] <= '0;
            end else if (wr_stb && addr == OFS_CAPT_A + 12'(c)) begin
               setup_reg[c] <= wdata[STEP_W+1:0]; // [RL6] [RL3]
            end
         end
         // Holds between matches; a match each frame refreshes it
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               capt_reg[c] <= '0;
            end else if (step_valid &&
                         prog_counter == setup_reg[c].capture_step) begin
               capt_reg[c] <= tap_word[WORD_W-1:DROP_LSB];
               // [RL2] [RL4] [RL5] [RL7] [RL21]
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rd_next;

   always_comb begin
      rd_next = '0;
      case (addr)
         OFS_CAPT_A: rd_next = capt_reg[0]; // [RL8]
         OFS_CAPT_B: rd_next = capt_reg[1]; // [RL8]
         OFS_CORE_CTRL: begin
            rd_next[15:0] = ctrl_reg; // [RL9]
            rd_next[B_GO] = load_busy; // [RL14]
         end
         default: begin
            if (addr >= OFS_LOAD_TGT0 &&
                addr < OFS_LOAD_TGT0 + 12'(LOAD_SLOTS)) begin
               rd_next[TGT_W-1:0] = tgt_flat[tgt_slot*TGT_W +: TGT_W];
               // [RL1]
            end
         end
      endcase
   end

   // Unmapped reads return zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_stb) begin
         rdata <= rd_next;
      end else begin
         rdata <= '0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_tgt_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
      rd_stb && wr_tgt == 1'b0 && addr == OFS_LOAD_TGT0
      |=> rdata[DATA_W-1:TGT_W] == '0)
      else $error("target address upper bits not zero");
   a_capture_match: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
      step_valid && prog_counter == setup_reg[0].capture_step &&
      setup_reg[0].capture_source_sel == SRC_MAC
      |=> capt_reg[0] == $past(taps.mac_result[WORD_W-1:DROP_LSB]))
      else $error("capture A missed the MAC result");
   a_capture_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RL21]
      !(step_valid && prog_counter == setup_reg[1].capture_step)
      |=> $stable(capt_reg[1]))
      else $error("capture B changed without a match");
   a_capture_read: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
      rd_stb && addr == OFS_CAPT_B |=> rdata == $past(capt_reg[1]))
      else $error("capture B read mismatch");
   a_go_no_restart: assert property (@(posedge clk) disable iff (!rst_n) // [RL20]
      load_busy && wr_ctrl |=> load_busy || $past(u_load.idx_reg) == 3'h4)
      else $error("control write disturbed a running safeload");
   a_go_start: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
      wr_ctrl && wdata[B_GO] && !load_busy |=> load_busy ##5 !load_busy)
      else $error("go bit did not start and self clear");
   a_mute_follow: assert property (@(posedge clk) disable iff (!rst_n) // [RL18]
      wr_ctrl && !wdata[B_ADC_UM] |=> ##1 !adc_unmute)
      else $error("ADC path not muted after clear of unmute");
   a_rate_decode: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
      wr_ctrl && wdata[1:0] == 2'h2 |=> ##1 instr_per_sample == IPS_4X)
      else $error("rate select 10 did not give 128 instructions");
   a_debounce_map: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
      wr_ctrl && wdata[13:12] == 2'h3
      |=> ##1 debounce_ticks == DEB_W'(DEB_CYC_11))
      else $error("debounce select 11 mismatch");
   a_clear_bit: assert property (@(posedge clk) disable iff (!rst_n) // [RL17]
      wr_ctrl |=> ##1 core_clear_n == $past(wdata[B_CLR_N], 2))
      else $error("clear bit not applied");
endmodule // dcc_core_ctrl
`default_nettype wire

/* File: design/dcc_pkg.sv */
// Constants and carrier types for the DSP core control and capture bank.
// Assumes a single 20 MHz DSP clock shared by the core and control port.
package dcc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 24;
   localparam logic [11:0] OFS_LOAD_TGT0 = 12'h815;
   localparam logic [11:0] OFS_CAPT_A = 12'h81A;
   localparam logic [11:0] OFS_CAPT_B = 12'h81B;
   localparam logic [11:0] OFS_CORE_CTRL = 12'h81C;
   localparam int LOAD_SLOTS = 5;
   localparam int TGT_W = 12;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] CTRL_MASK = 16'h31FF;
   // ------------------------------------------------------------
   // Core control field positions
   // ------------------------------------------------------------
   localparam int B_DEB_LO = 12;
   localparam int B_AUX_HW = 8;
   localparam int B_PIN_HW = 7;
   localparam int B_IF_HW = 6;
   localparam int B_GO = 5;
   localparam int B_ADC_UM = 4;
   localparam int B_DAC_UM = 3;
   localparam int B_CLR_N = 2;
   localparam int B_RATE_LO = 0;
   // ------------------------------------------------------------
   // Capture setup and data
   // ------------------------------------------------------------
   localparam int STEP_W = 10;
   localparam int WORD_W = 28;
   localparam int DROP_LSB = 4;
   localparam logic [1:0] SRC_MUL_X = 2'h0;
   localparam logic [1:0] SRC_MUL_Y = 2'h1;
   localparam logic [1:0] SRC_MAC = 2'h2;
   localparam logic [1:0] SRC_ACC = 2'h3;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int DEB_MS_00 = 20;
   localparam int DEB_MS_01 = 40;
   localparam int DEB_MS_10 = 10;
   localparam int DEB_MS_11 = 5;
   localparam int DEB_W = 20;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam logic [10:0] IPS_1X = 11'h200;
   localparam logic [10:0] IPS_2X = 11'h100;
   localparam logic [10:0] IPS_4X = 11'h080;

   typedef struct packed {
      logic [WORD_W-1:0] mul_x;
      logic [WORD_W-1:0] mul_y;
      logic [WORD_W-1:0] mac_result;
      logic [WORD_W-1:0] acc_fb;
   } dcc_tap_s;

   typedef struct packed {
      logic [STEP_W-1:0] capture_step;
      logic [1:0] capture_source_sel;
   } dcc_setup_s;
endpackage

/* File: design/dcc_safeload.sv */
// Safeload sequencer: five target address slots with written flags.
// Assumes start is a single-cycle pulse issued only while idle.
`timescale 1ns/10ps
`default_nettype none
module dcc_safeload import dcc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host side
   input wire logic tgt_we,
   input wire logic [2:0] tgt_slot,
   input wire logic [TGT_W-1:0] tgt_addr,
   input wire logic start,
   // State and transfer
   output logic busy,
   output logic [LOAD_SLOTS*TGT_W-1:0] tgt_flat,
   output logic ld_valid,
   output logic [2:0] ld_slot,
   output logic [TGT_W-1:0] ld_addr
);
   logic [TGT_W-1:0] tgt_reg [LOAD_SLOTS];
   logic [LOAD_SLOTS-1:0] pend_reg;
   logic [2:0] idx_reg;

   genvar g;
   generate
      for (g = 0; g < LOAD_SLOTS; g++) begin : g_slot
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               tgt_reg[g] <= '0;
            end else if (tgt_we && tgt_slot == 3'(g)) begin
               tgt_reg[g] <= tgt_addr;
            end
         end
         assign tgt_flat[g*TGT_W +: TGT_W] = tgt_reg[g];
         // A fresh write in the cycle of transfer keeps the slot pending
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pend_reg[g] <= 1'b0;
            end else if (tgt_we && tgt_slot == 3'(g)) begin
               pend_reg[g] <= 1'b1; // [RL15]
            end else if (busy && idx_reg == 3'(g)) begin
               pend_reg[g] <= 1'b0; // [RL15]
            end
         end
      end
   endgenerate

   // One slot per cycle, so the whole set ends within five cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         idx_reg <= '0;
      end else if (!busy) begin
         busy <= start; // [RL14]
         idx_reg <= '0;
      end else if (idx_reg == 3'(LOAD_SLOTS - 1)) begin
         // Index wraps to zero so no slot beyond the last is ever looked up
         busy <= 1'b0; // [RL14] [RL19]
         idx_reg <= '0;
      end else begin
         idx_reg <= idx_reg + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ld_valid <= 1'b0;
         ld_slot <= '0;
         ld_addr <= '0;
      end else begin
         ld_valid <= busy && pend_reg[idx_reg]; // [RL15]
         ld_slot <= idx_reg;
         ld_addr <= tgt_reg[idx_reg];
      end
   end

   a_load_bound: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy) |-> ##5 !busy) // [RL19]
      else $error("safeload did not end in five cycles");
   a_skip_unwritten: assert property (@(posedge clk) disable iff (!rst_n)
      busy && !pend_reg[idx_reg] |=> !ld_valid) // [RL15]
      else $error("unwritten slot was transferred");
endmodule // dcc_safeload
`default_nettype wire

/* File: tb/dcc_host.sv */
// Host model that drives the control port of the capture and control bank.
// Assumes one rising-edge clock shared with the bank and no wait states.
`timescale 1ns/10ps
`default_nettype none
module dcc_host import dcc_pkg::*; (
   // Clock
   input wire logic clk,
   // Control port
   output logic [ADDR_W-1:0] addr,
   output logic [15:0] wdata,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [DATA_W-1:0] rdata
);
   initial begin
      addr = '0;
      wdata = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // Step index above the source select, upper nibble zero
   function automatic logic [15:0] setup_word(input logic [STEP_W-1:0] s,
                                              input logic [1:0] r);
      return {4'h0, s, r};
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe, so sample right then
   task automatic rd(input logic [ADDR_W-1:0] a,
                     output logic [DATA_W-1:0] q);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      q = rdata;
   endtask
endmodule // dcc_host
`default_nettype wire

/* File: tb/dsp_core_control_capture_bench.sv */
// Self-checking bench for the core control and capture register bank.
// Assumes the host model in dcc_host and short debounce parameters.
`timescale 1ns/10ps
`default_nettype none
module dsp_core_control_capture_bench import dcc_pkg::*;;
   localparam int D0 = 10;
   localparam int D1 = 20;
   localparam int D2 = 30;
   localparam int D3 = 40;
   localparam int IPS_E [4] = '{512, 256, 128, 512};
   localparam int DEB_E [4] = '{D0, D1, D2, D3};
   // Negative values and non-zero low nibbles expose sign and truncation
   localparam dcc_tap_s T0 = {28'h8ABCDE5, 28'h1234567, 28'hF00000F,
                              28'h7FFFFF8};
   logic clk, resetn, wr_stb, rd_stb, step_valid;
   logic [ADDR_W-1:0] addr;
   logic [15:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic [STEP_W-1:0] prog_counter;
   dcc_tap_s taps;
   logic clr_n, adc_um, dac_um, aux_hw, pin_hw, if_hw, go, ld_valid;
   logic [1:0] rate_sel, deb_sel;
   logic [10:0] ips;
   logic [DEB_W-1:0] deb_ticks;
   logic [2:0] ld_slot;
   logic [TGT_W-1:0] tgt;
   logic [14:0] ld_q [$];
   int n_fail = 0;
   int tests_run = 0;

   dcc_host dcc_host_i (.clk(clk), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

   dcc_core_ctrl #(.DEB_CYC_00(D0), .DEB_CYC_01(D1), .DEB_CYC_10(D2),
      .DEB_CYC_11(D3)) dcc_core_ctrl_i (.clk(clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .step_valid(step_valid), .prog_counter(prog_counter),
      .taps(taps), .core_clear_n(clr_n), .adc_unmute(adc_um),
      .dac_unmute(dac_um), .rate_multiplier_sel(rate_sel),
      .instr_per_sample(ips), .input_debounce_sel(deb_sel),
      .debounce_ticks(deb_ticks), .aux_conv_host_write(aux_hw),
      .pin_host_write(pin_hw), .iface_host_write(if_hw),
      .safeload_go(go), .ld_valid(ld_valid), .ld_slot(ld_slot),
      .param_target_addr(tgt));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (ld_valid === 1'b1) begin
         ld_q.push_back({ld_slot, tgt});
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                      input string m);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [23:0] pick(input logic [1:0] r,
                                        input dcc_tap_s t);
      case (r)
         2'h0: return t.mul_x[27:4];
         2'h1: return t.mul_y[27:4];
         2'h2: return t.mac_result[27:4];
         default: return t.acc_fb[27:4];
      endcase
   endfunction

   task automatic run_frame();
      for (int pc = 0; pc < 1024; pc++) begin
         @(posedge clk);
         step_valid <= 1'b1;
         prog_counter <= pc[STEP_W-1:0];
      end
      @(posedge clk);
      step_valid <= 1'b0;
   endtask

   // Start a transfer; optionally write zero to the control word mid-run
   task automatic go_load(input bit kill);
      logic [23:0] q;
      int n;
      ld_q.delete();
      dcc_host_i.wr(OFS_CORE_CTRL, 16'h0020);
      for (n = 0; n < 4 && go !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk(24'(go), 24'h1, "go not raised");
      if (kill) begin
         dcc_host_i.wr(OFS_CORE_CTRL, 16'h0000);
      end
      for (n = 0; n < 512 && go !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk(24'(go), 24'h0, "load too long");
      dcc_host_i.rd(OFS_CORE_CTRL, q);
      chk(24'(q[5]), 24'h0, "go bit stuck");
   endtask

   initial begin
      #(50 * 20000);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      logic [23:0] q;
      logic [15:0] w;
      resetn = 1'b0;
      step_valid = 1'b0;
      prog_counter = '0;
      taps = T0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      // ---------------------------------------------------------------
      // Reset state and register map
      // ---------------------------------------------------------------
      chk(24'({clr_n, adc_um, dac_um}), 24'h0, "mute reset");
      chk(24'(ips), 24'h200, "ips reset");
      chk(24'(deb_ticks), 24'(D0), "ticks reset");
      dcc_host_i.rd(OFS_CORE_CTRL, q);
      chk(q, 24'h0, "ctrl reset");
      for (int i = 0; i < 5; i++) begin
         w = 16'hFABC ^ 16'(i);
         dcc_host_i.rd(OFS_LOAD_TGT0 + 12'(i), q);
         chk(q, 24'h0, "target reset");
         dcc_host_i.wr(OFS_LOAD_TGT0 + 12'(i), w);
         dcc_host_i.rd(OFS_LOAD_TGT0 + 12'(i), q);
         chk(q, 24'(w[11:0]), "target bits");
      end
      dcc_host_i.wr(12'h81D, 16'hFFFF);
      dcc_host_i.rd(12'h81D, q);
      chk(q, 24'h0, "unmapped read");
      // ---------------------------------------------------------------
      // Control fields, every rate and debounce code
      // ---------------------------------------------------------------
      for (int i = 0; i < 4; i++) begin
         w = 16'hCFDC | 16'(i << 12) | 16'(i);
         dcc_host_i.wr(OFS_CORE_CTRL, w);
         dcc_host_i.rd(OFS_CORE_CTRL, q);
         chk(q, 24'(w & CTRL_MASK), "ctrl readback");
         chk(24'(ips), 24'(IPS_E[i]), "ips");
         chk(24'(deb_ticks), 24'(DEB_E[i]), "ticks");
         chk(24'({deb_sel, rate_sel}), 24'(i * 5), "sel");
         chk(24'({aux_hw, pin_hw, if_hw}), 24'h7, "hw");
         chk(24'({clr_n, adc_um, dac_um}), 24'h7, "on");
      end
      dcc_host_i.wr(OFS_CORE_CTRL, 16'h0000);
      dcc_host_i.rd(OFS_CORE_CTRL, q);
      chk(24'({aux_hw, pin_hw, if_hw, clr_n, adc_um, dac_um}), 24'h0,
          "off");
      // ---------------------------------------------------------------
      // Safeload: all pending, none pending, one pending with zero write
      // ---------------------------------------------------------------
      go_load(1'b0);
      chk(24'(ld_q.size()), 24'd5, "five slots");
      for (int i = 0; i < 5 && i < ld_q.size(); i++) begin
         w = 16'hFABC ^ 16'(i);
         chk(24'(ld_q[i]), 24'({3'(i), w[11:0]}), "slot order");
      end
      go_load(1'b0);
      chk(24'(ld_q.size()), 24'd0, "stale slots");
      dcc_host_i.wr(OFS_LOAD_TGT0 + 12'h3, 16'h0123);
      go_load(1'b1);
      chk(24'(ld_q.size()), 24'd1, "zero write stopped");
      chk(24'(ld_q[0]), 24'({3'h3, 12'h123}), "slot three");
      // ---------------------------------------------------------------
      // Capture every source on both registers, steps 5 and 1023
      // ---------------------------------------------------------------
      for (int r = 0; r < 4; r++) begin
         dcc_host_i.wr(OFS_CAPT_A, dcc_host_i.setup_word(10'h005, 2'(r)));
         dcc_host_i.wr(OFS_CAPT_B, dcc_host_i.setup_word(10'h3FF, 2'(3 - r)));
         run_frame();
         dcc_host_i.rd(OFS_CAPT_A, q);
         chk(q, pick(2'(r), T0), "capture a");
         dcc_host_i.rd(OFS_CAPT_B, q);
         chk(q, pick(2'(3 - r), T0), "capture b");
      end
      // Matching step without the valid flag must not capture
      @(posedge clk);
      taps <= ~T0;
      prog_counter <= 10'h005;
      repeat (3) @(posedge clk);
      dcc_host_i.rd(OFS_CAPT_A, q);
      chk(q, pick(2'h3, T0), "capture hold");
      run_frame();
      dcc_host_i.rd(OFS_CAPT_A, q);
      chk(q, pick(2'h3, ~T0), "capture refresh");
      summarize();
   end
endmodule // dsp_core_control_capture_bench
`default_nettype wire
